// file: pss_defines.vh
// constants of the power state sequencer: offsets, fields, resets, timing
// assumes a single 200 MHz clock; ms timing counts off a ms tick, the enable pin delay counts clock cycles
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define PSS_CLK_MHZ        200
`define PSS_CLK_HZ         200000000
`define PSS_MS_CYCLES      (`PSS_CLK_HZ / 1000)
`define PSS_EN_DLY_NS      450000
`define PSS_EN_DLY_CYCLES  ((`PSS_EN_DLY_NS * `PSS_CLK_MHZ) / 1000)
`define PSS_BTN_ON_MS      13'h0190
`define PSS_BTN_IRQ_MS     13'h0032
`define PSS_CONFIRM_MS     13'h1388
`define PSS_OFF_MS         13'h03E8
`define PSS_SQD_STEP_MS    9'h064

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PSS_ADDR_CONTROL   3'h0
`define PSS_ADDR_BUCK_SQD  3'h1
`define PSS_ADDR_LIN_SQD   3'h2
`define PSS_ADDR_REG_EN    3'h3
`define PSS_ADDR_KEEP      3'h4
`define PSS_ADDR_INTERRUPT_STATUS_REGISTER   3'h5
`define PSS_ADDR_HARD_RESET_CMD  3'h6
`define PSS_ADDR_STATE     3'h7

// ----------------------------------------------------------------------
// control and interrupt status register fields
// ----------------------------------------------------------------------
`define PSS_CTL_SW_HOLD    7
`define PSS_CTL_SW_CTRL    5
`define PSS_CTL_UVW_HI     4
`define PSS_CTL_UVW_LO     2
`define PSS_IRQ_BUTTON     0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PSS_RST_CONTROL    8'h00
`define PSS_RST_BUCK_SQD   8'h00
`define PSS_RST_LIN_SQD    8'h00
`define PSS_RST_REG_EN     7'h00
`define PSS_RST_KEEP       7'h00

`endif

// file: pss_host_model.sv
// host processor model on the far side of the power hold pin
// assumes wake_q from the sequencer and bench requests on clk
`timescale 1ns/1ps
module pss_host_model #(
    parameter RESP_CYCLES = 100
) (
    // clock and reset
    input  wire clk,
    input  wire rst,
    // sequencer side
    input  wire wake_q,
    output reg  power_hold_q,
    // bench requests
    input  wire want_on,
    input  wire drop_hold
);
    int cnt_q;
    // answers wake late: the device must not rely on a quick host
    always @(posedge clk) begin
        if (rst || !wake_q)
            cnt_q <= 0;
        else if (cnt_q < RESP_CYCLES)
            cnt_q <= cnt_q + 1;
        if (rst || drop_hold)
            power_hold_q <= 1'b0;
        else if (want_on || cnt_q == RESP_CYCLES)
            power_hold_q <= 1'b1;
    end
endmodule // pss_host_model

// file: pss_rail.v
// one regulator enable path: pin delay, source select and down sequence
// assumes pin input already synchronised and a one-cycle ms tick
`timescale 1ns/1ps
`include "pss_defines.vh"

module pss_rail #(
    parameter EN_DLY_CYCLES = `PSS_EN_DLY_CYCLES,
    parameter DLY_W         = 17
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // timing and state
    input  wire       ms_tick,
    input  wire       allowed,
    input  wire       down,
    // configuration
    input  wire [1:0] sqd_sel,
    input  wire       sw_mode,
    input  wire       sw_bit,
    input  wire       keep,
    // enable pin, synchronised
    input  wire       pin_s,
    // regulator enable
    output reg        rail_en_q
);

    reg  [DLY_W-1:0] dly_cnt_q;
    reg              pin_dly_q;
    reg              down_q;
    reg              held_q;
    reg  [8:0]       dn_ms_q;
    wire [8:0]       dn_limit;
    wire             src;
    reg              rail_en_d;

    // ------------------------------------------------------------------
    // pin to internal enable delay
    // ------------------------------------------------------------------
    // pin must stay at its new level the whole delay before it counts
    always @(posedge clk) begin
        if (rst) begin
            dly_cnt_q <= {DLY_W{1'b0}};
            pin_dly_q <= 1'b0;
        end else if (pin_s == pin_dly_q) begin
            dly_cnt_q <= {DLY_W{1'b0}};
        end else if (dly_cnt_q == EN_DLY_CYCLES - 1) begin
            dly_cnt_q <= {DLY_W{1'b0}};
            pin_dly_q <= pin_s;
        end else begin
            dly_cnt_q <= dly_cnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // down sequence timed from the fall of wake
    // ------------------------------------------------------------------
    assign dn_limit = {7'h00, sqd_sel} * `PSS_SQD_STEP_MS;

    always @(posedge clk) begin
        if (rst) begin
            down_q  <= 1'b0;
            held_q  <= 1'b0;
            dn_ms_q <= 9'h000;
        end else begin
            down_q <= down;
            if (down && !down_q) begin
                held_q  <= rail_en_q;
                dn_ms_q <= 9'h000;
            end else if (down && ms_tick && dn_ms_q != 9'h1FF) begin
                dn_ms_q <= dn_ms_q + 9'h001;
            end
        end
    end

    // ------------------------------------------------------------------
    // enable source
    // ------------------------------------------------------------------
    assign src = sw_mode ? sw_bit : pin_dly_q;

    always @* begin
        rail_en_d = 1'b0;
        if (keep)
            rail_en_d = 1'b1;
        else if (allowed)
            rail_en_d = src;
        else if (down)
            rail_en_d = (down_q ? held_q : rail_en_q)
                        && (dn_ms_q < dn_limit);
    end

    always @(posedge clk) begin
        if (rst)
            rail_en_q <= 1'b0;
        else
            rail_en_q <= rail_en_d;
    end

endmodule // pss_rail

// file: pss_seq_asserts.sv
// port assertions of the power state sequencer
// assumes binding into pss_sequencer; slow counts follow MS_CYCLES
`timescale 1ns/1ps
module pss_seq_asserts #(
    parameter MS_CYCLES = 20,
    parameter NUM_RAILS = 7
) (
    // clock and reset
    input wire                 clk,
    input wire                 rst,
    // inputs
    input wire                 button_n,
    input wire                 uv_fault_in,
    input wire                 ot_hot_in,
    input wire                 reg_wr_en,
    input wire                 reg_rd_en,
    input wire [2:0]           reg_addr,
    input wire [7:0]           reg_wdata,
    // outputs
    input wire [7:0]           reg_rdata_q,
    input wire                 wake_q,
    input wire                 irq_n_q,
    input wire [NUM_RAILS-1:0] rail_en,
    input wire                 always_on_en,
    input wire [2:0]           undervoltage_warning_select
);
    localparam int MIN50 = 49 * MS_CYCLES;
    localparam int OFF_T = 1002 * MS_CYCLES;
    int         btn_lo_q, irq_lo_q, wake_lo_q;
    logic       keep_q;
    logic [7:0] wd_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // helpers
    // ----
    // wake low count saturates so a long standby cannot wrap
    always @(posedge clk) begin
        btn_lo_q <= button_n ? 0 : btn_lo_q + 1;
        irq_lo_q <= irq_n_q ? 0 : irq_lo_q + 1;
        wd_q <= reg_wdata;
        if (rst || wake_q)
            wake_lo_q <= 0;
        else if (wake_lo_q <= OFF_T)
            wake_lo_q <= wake_lo_q + 1;
        if (rst || uv_fault_in || ot_hot_in)
            keep_q <= 1'b0;
        else if (reg_wr_en && reg_addr == 3'h4)
            keep_q <= |reg_wdata[6:0];
    end
    always_on_a: assert property (always_on_en == 1'b1)
        else $error("always-on enable low");
    uvw_field_a: assert property (
        reg_wr_en && reg_addr == 3'h0 && wake_q
        |=> undervoltage_warning_select == wd_q[4:2])
        else $error("warning select not written");
    irq_read_a: assert property (
        reg_rd_en && reg_addr == 3'h5 |=> reg_rdata_q[0] == !irq_n_q)
        else $error("button flag and interrupt disagree");
    rdata_hold_a: assert property (
        !reg_rd_en |=> $stable(reg_rdata_q))
        else $error("read data moved without a read");
    irq_cause_a: assert property (
        $fell(irq_n_q) |-> btn_lo_q >= MIN50)
        else $error("interrupt without a 50 ms press");
    irq_min_a: assert property (
        $rose(irq_n_q) |-> irq_lo_q >= MIN50)
        else $error("interrupt released early");
    rails_off_a: assert property (
        wake_lo_q > OFF_T && !keep_q |-> rail_en == '0)
        else $error("rail on in an inhibited state");
    fault_drop_a: assert property (
        (uv_fault_in || ot_hot_in) [*3] |-> ##[0:2] !wake_q)
        else $error("wake held through a fault");
endmodule // pss_seq_asserts

bind pss_sequencer pss_seq_asserts #(
    .MS_CYCLES(MS_CYCLES),
    .NUM_RAILS(NUM_RAILS)
) u_seq_chk (
    .clk, .rst, .button_n, .uv_fault_in, .ot_hot_in, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_q, .wake_q, .irq_n_q,
    .rail_en, .always_on_en, .undervoltage_warning_select
);

// file: pss_sequencer.v
// operating-mode state controller of a multi-rail power manager
// assumes a register port behind the two-wire decoder and analog comparators
// that present fault levels as pins; all pins are sampled on clk
`timescale 1ns/1ps
`include "pss_defines.vh"

module pss_sequencer #(
    parameter MS_CYCLES     = `PSS_MS_CYCLES,
    parameter EN_DLY_CYCLES = `PSS_EN_DLY_CYCLES,
    parameter NUM_RAILS     = 7
) (
    // clock and reset
    input  wire                 clk,
    input  wire                 rst,
    // pins from the board
    input  wire                 button_n,
    input  wire                 power_hold_in,
    input  wire [NUM_RAILS-1:0] enable_pins,
    // comparator levels
    input  wire                 uv_fault_in,
    input  wire                 ot_hot_in,
    input  wire                 ot_cool_in,
    // command register port
    input  wire                 reg_wr_en,
    input  wire                 reg_rd_en,
    input  wire [2:0]           reg_addr,
    input  wire [7:0]           reg_wdata,
    output reg  [7:0]           reg_rdata_q,
    // outputs
    output reg                  wake_q,
    output reg                  irq_n_q,
    output wire [NUM_RAILS-1:0] rail_en,
    output wire                 always_on_en,
    output wire [2:0]           undervoltage_warning_select
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [2:0] ST_COLD    = 3'h0;
    localparam [2:0] ST_CONFIRM = 3'h1;
    localparam [2:0] ST_ON      = 3'h2;
    localparam [2:0] ST_OFF_HR  = 3'h3;
    localparam [2:0] ST_OFF_SB  = 3'h4;
    localparam [2:0] ST_STANDBY = 3'h5;
    localparam       SW        = NUM_RAILS + 5;

    reg  [SW-1:0]        sync1_q;
    reg  [SW-1:0]        sync2_q;
    reg  [17:0]          tb_cnt_q;
    reg                  ms_tick_q;
    reg  [2:0]           state_q;
    reg  [2:0]           state_d;
    reg  [12:0]          st_ms_q;
    reg  [12:0]          btn_ms_q;
    reg  [12:0]          irq_ms_q;
    reg                  button_flag_q;
    reg                  ot_fault_q;
    reg  [7:0]           control_register_q;
    reg  [7:0]           buck_power_down_delays_q;
    reg  [7:0]           linear_power_down_delays_q;
    reg  [NUM_RAILS-1:0] reg_en_q;
    reg  [NUM_RAILS-1:0] keep_q;
    wire                 btn_low;
    wire                 hold_s;
    wire                 uv_s;
    wire                 ot_hot_s;
    wire                 ot_cool_s;
    wire [NUM_RAILS-1:0] pins_s;
    wire                 fault;
    wire                 hold_req;
    wire                 off_done;
    wire                 allowed;
    wire                 down;
    wire                 fault_shut;
    wire [13:0]          sqd_all;
    wire                 wr_hard_reset;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // second stage is the only reader of the first
    always @(posedge clk) begin
        if (rst) begin
            sync1_q <= {SW{1'b0}};
            sync2_q <= {SW{1'b0}};
        end else begin
            sync1_q <= {enable_pins, ot_cool_in, ot_hot_in, uv_fault_in,
                        power_hold_in, ~button_n};
            sync2_q <= sync1_q;
        end
    end

    assign btn_low   = sync2_q[0];
    assign hold_s    = sync2_q[1];
    assign uv_s      = sync2_q[2];
    assign ot_hot_s  = sync2_q[3];
    assign ot_cool_s = sync2_q[4];
    assign pins_s    = sync2_q[SW-1:5];

    // ------------------------------------------------------------------
    // time base: one-cycle ms tick
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            tb_cnt_q  <= 18'h00000;
            ms_tick_q <= 1'b0;
        end else if (tb_cnt_q == MS_CYCLES - 1) begin
            tb_cnt_q  <= 18'h00000;
            ms_tick_q <= 1'b1;
        end else begin
            tb_cnt_q  <= tb_cnt_q + 18'h00001;
            ms_tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // faults
    // ------------------------------------------------------------------
    // hysteresis latch; hot wins if both comparators assert
    always @(posedge clk) begin
        if (rst)
            ot_fault_q <= 1'b0;
        else if (ot_hot_s)
            ot_fault_q <= 1'b1;
        else if (ot_cool_s)
            ot_fault_q <= 1'b0;
    end

    assign fault    = uv_s | ot_fault_q;
    assign hold_req = hold_s | control_register_q[`PSS_CTL_SW_HOLD];
    assign wr_hard_reset  = reg_wr_en && (reg_addr == `PSS_ADDR_HARD_RESET_CMD);

    // ------------------------------------------------------------------
    // button low-time counter, saturating
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst || !btn_low)
            btn_ms_q <= 13'h0000;
        else if (ms_tick_q && btn_ms_q != `PSS_BTN_ON_MS)
            btn_ms_q <= btn_ms_q + 13'h0001;
    end

    // ------------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------------
    assign off_done = ms_tick_q && (st_ms_q == `PSS_OFF_MS - 13'h0001);

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_COLD, ST_STANDBY: begin
                if (!fault && ms_tick_q && btn_low
                    && btn_ms_q == `PSS_BTN_ON_MS - 13'h0001)
                    state_d = ST_CONFIRM;
                else if (!fault && hold_req)
                    state_d = ST_CONFIRM;
            end
            ST_CONFIRM: begin
                if (fault)
                    state_d = ST_OFF_SB;
                else if (ms_tick_q
                         && st_ms_q == `PSS_CONFIRM_MS - 13'h0001)
                    state_d = hold_req ? ST_ON : ST_OFF_SB;
            end
            ST_ON: begin
                if (wr_hard_reset)
                    state_d = ST_OFF_HR;
                else if (fault || !hold_req)
                    state_d = ST_OFF_SB;
            end
            ST_OFF_HR: begin
                if (off_done)
                    state_d = ST_COLD;
            end
            ST_OFF_SB: begin
                if (off_done)
                    state_d = ST_STANDBY;
            end
            default: state_d = ST_COLD;
        endcase
    end

    // state timer restarts on every change of state
    always @(posedge clk) begin
        if (rst) begin
            state_q <= ST_COLD;
            st_ms_q <= 13'h0000;
        end else begin
            state_q <= state_d;
            if (state_d != state_q)
                st_ms_q <= 13'h0000;
            else if (ms_tick_q && st_ms_q != 13'h1FFF)
                st_ms_q <= st_ms_q + 13'h0001;
        end
    end

    // wake per state; confirm timer keeps it up the full 5 s unless a fault ends confirm
    always @(posedge clk) begin
        if (rst)
            wake_q <= 1'b0;
        else
            wake_q <= (state_d == ST_CONFIRM)
                      || (state_d == ST_ON);
    end

    assign allowed = (state_q == ST_CONFIRM) || (state_q == ST_ON);
    assign down    = (state_q == ST_OFF_HR) || (state_q == ST_OFF_SB);
    assign fault_shut = fault && (state_q == ST_CONFIRM || state_q == ST_ON);

    // ------------------------------------------------------------------
    // button flag and interrupt
    // ------------------------------------------------------------------
    // the flag is real time, so it drops on its own once released, but no sooner than 50 ms after it set
    always @(posedge clk) begin
        if (rst) begin
            button_flag_q <= 1'b0;
            irq_ms_q      <= 13'h0000;
        end else if (state_q == ST_ON && btn_low && ms_tick_q
                     && btn_ms_q == `PSS_BTN_IRQ_MS - 13'h0001) begin
            button_flag_q <= 1'b1;
            irq_ms_q      <= 13'h0000;
        end else if (button_flag_q) begin
            if (ms_tick_q && irq_ms_q != `PSS_BTN_IRQ_MS)
                irq_ms_q <= irq_ms_q + 13'h0001;
            if (!btn_low && irq_ms_q == `PSS_BTN_IRQ_MS)
                button_flag_q <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (rst)
            irq_n_q <= 1'b1;
        else
            irq_n_q <= ~button_flag_q;
    end

    // ------------------------------------------------------------------
    // command registers
    // ------------------------------------------------------------------
    // state-driven clears are placed after the write so they win over it
    always @(posedge clk) begin
        if (rst || state_q == ST_OFF_HR) begin
            control_register_q         <= `PSS_RST_CONTROL;
            buck_power_down_delays_q   <= `PSS_RST_BUCK_SQD;
            linear_power_down_delays_q <= `PSS_RST_LIN_SQD;
            reg_en_q                   <= `PSS_RST_REG_EN;
            keep_q                     <= `PSS_RST_KEEP;
        end else begin
            if (reg_wr_en) begin
                case (reg_addr)
                    `PSS_ADDR_CONTROL:  control_register_q <= reg_wdata;
                    `PSS_ADDR_BUCK_SQD:
                        buck_power_down_delays_q <= reg_wdata;
                    `PSS_ADDR_LIN_SQD:
                        linear_power_down_delays_q <= {2'b00, reg_wdata[5:0]};
                    `PSS_ADDR_REG_EN:   reg_en_q <= reg_wdata[NUM_RAILS-1:0];
                    `PSS_ADDR_KEEP:     keep_q <= reg_wdata[NUM_RAILS-1:0];
                    default: ;
                endcase
            end
            if (state_q == ST_OFF_SB) begin
                reg_en_q <= {NUM_RAILS{1'b0}};
                control_register_q[`PSS_CTL_SW_CTRL] <= 1'b0;
            end
            if (state_q == ST_STANDBY || state_q == ST_COLD)
                reg_en_q <= {NUM_RAILS{1'b0}};
            if (fault_shut)
                keep_q <= {NUM_RAILS{1'b0}};
        end
    end

    // read data registered; unused addresses read zero
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                `PSS_ADDR_CONTROL:  reg_rdata_q <= control_register_q;
                `PSS_ADDR_BUCK_SQD: reg_rdata_q <= buck_power_down_delays_q;
                `PSS_ADDR_LIN_SQD:  reg_rdata_q <= linear_power_down_delays_q;
                `PSS_ADDR_REG_EN:   reg_rdata_q <= {1'b0, reg_en_q};
                `PSS_ADDR_KEEP:     reg_rdata_q <= {1'b0, keep_q};
                `PSS_ADDR_INTERRUPT_STATUS_REGISTER:  reg_rdata_q <= {7'h00, button_flag_q};
                `PSS_ADDR_STATE:    reg_rdata_q <= {5'h00, state_q};
                default:            reg_rdata_q <= 8'h00;
            endcase
        end
    end

    assign undervoltage_warning_select =
        control_register_q[`PSS_CTL_UVW_HI:`PSS_CTL_UVW_LO];

    // ------------------------------------------------------------------
    // rails: bucks 1-4 then linear 2-4
    // ------------------------------------------------------------------
    assign sqd_all = {linear_power_down_delays_q[5:0],
                      buck_power_down_delays_q};
    assign always_on_en = 1'b1;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_RAILS; gi = gi + 1) begin : g_rail
            pss_rail #(
                .EN_DLY_CYCLES (EN_DLY_CYCLES)
            ) u_rail (
                .clk       (clk),
                .rst       (rst),
                .ms_tick   (ms_tick_q),
                .allowed   (allowed),
                .down      (down),
                .sqd_sel   (sqd_all[2*gi+1:2*gi]),
                .sw_mode   (control_register_q[`PSS_CTL_SW_CTRL]),
                .sw_bit    (reg_en_q[gi]),
                .keep      (keep_q[gi]),
                .pin_s     (pins_s[gi]),
                .rail_en_q (rail_en[gi])
            );
        end
    endgenerate

endmodule // pss_sequencer

// file: tb.sv
// self-checking bench of the power state sequencer
// assumes the host model beside it and the bound port checker
`timescale 1ns/1ps
module tb;
    localparam int MS = 10;
    localparam int EN_DLY = 9;
    logic       clk, rst, button_n, uv, hot, cool;
    logic       wr_en, rd_en, want_on, drop_hold;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [6:0] pins;
    logic [7:0] dn_exp [4] = '{8'h6E, 8'h6C, 8'h28, 8'h20};
    wire  [7:0] rdata;
    wire        hold, wake, irq_n;
    wire  [6:0] rail;
    wire  [2:0] uvw;
    int         err_count, tests_run, n;

    pss_sequencer #(.MS_CYCLES(MS), .EN_DLY_CYCLES(EN_DLY)) u_dut (
        .clk(clk), .rst(rst), .button_n(button_n), .power_hold_in(hold),
        .enable_pins(pins), .uv_fault_in(uv), .ot_hot_in(hot),
        .ot_cool_in(cool), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_q(rdata),
        .wake_q(wake), .irq_n_q(irq_n), .rail_en(rail),
        .always_on_en(), .undervoltage_warning_select(uvw));
    pss_host_model u_host (.clk(clk), .rst(rst), .wake_q(wake),
        .power_hold_q(hold), .want_on(want_on), .drop_hold(drop_hold));

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one-cycle strobes, driven and released on falling edges
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        chk(rdata, exp);
    endtask
    task automatic ms(input int k);
        repeat (k * MS) @(negedge clk);
    endtask
    // bounded wait; a hang ends the run with a mismatch
    task automatic wait_wake(input logic lvl);
        n = 0;
        while (wake !== lvl) begin
            @(negedge clk);
            n++;
            if (n > 60000) begin
                err_count++;
                close_out();
            end
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rst, cool, button_n, pins} = {3'h7, 7'h7F};
        {uv, hot, wr_en, rd_en, want_on, drop_hold} = 6'h00;
        {addr, wdata, err_count, tests_run} = '0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        ms(2);
        chk({wake, rail}, 8'h00);
        rd(3'h7, 8'h00);
        rd(3'h0, 8'h00);
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h00);
        $display("test cold reset done");
        button_n = 1'b0;
        wait_wake(1'b1);
        chk({7'h0, n >= 399 * MS && n <= 401 * MS + 4}, 8'h01);
        button_n = 1'b1;
        rd(3'h7, 8'h01);
        repeat (EN_DLY + 6) @(negedge clk);
        chk({1'b0, rail}, 8'h7F);
        pins[0] = 1'b0;
        repeat (EN_DLY - 3) @(negedge clk);
        chk({7'h0, rail[0]}, 8'h01);
        repeat (8) @(negedge clk);
        chk({7'h0, rail[0]}, 8'h00);
        ms(5000);
        rd(3'h7, 8'h02);
        $display("test button power-up done");
        wr(3'h0, 8'hA0);
        wr(3'h3, 8'h05);
        repeat (4) @(negedge clk);
        chk({1'b0, rail}, 8'h05);
        wr(3'h0, 8'h94);
        rd(3'h0, 8'h94);
        chk({5'h0, uvw}, 8'h05);
        repeat (EN_DLY + 6) @(negedge clk);
        chk({1'b0, rail}, 8'h7E);
        button_n = 1'b0;
        ms(60);
        chk({7'h0, irq_n}, 8'h00);
        rd(3'h5, 8'h01);
        button_n = 1'b1;
        ms(20);
        chk({7'h0, irq_n}, 8'h00);
        ms(25);
        chk({7'h0, irq_n}, 8'h01);
        $display("test software mode and button flag done");
        wr(3'h1, 8'hE4);
        wr(3'h2, 8'h20);
        wr(3'h4, 8'h20);
        rd(3'h4, 8'h20);
        wr(3'h3, 8'h7E);
        wr(3'h0, 8'hB4);
        drop_hold = 1'b1;
        wr(3'h0, 8'h34);
        wait_wake(1'b0);
        ms(50);
        for (int i = 0; i < 4; i++) begin
            chk({1'b0, rail}, dn_exp[i]);
            ms(100);
        end
        ms(560);
        rd(3'h7, 8'h05);
        rd(3'h3, 8'h00);
        rd(3'h0, 8'h14);
        chk({1'b0, rail}, 8'h20);
        $display("test power-down sequence done");
        drop_hold = 1'b0;
        want_on = 1'b1;
        wait_wake(1'b1);
        chk({7'h0, n < 8}, 8'h01);
        cool = 1'b0;
        hot = 1'b1;
        repeat (5) @(negedge clk);
        hot = 1'b0;
        wait_wake(1'b0);
        chk({7'h0, n < 8}, 8'h01);
        ms(1010);
        rd(3'h7, 8'h05);
        rd(3'h4, 8'h00);
        chk({wake, rail}, 8'h00);
        cool = 1'b1;
        wait_wake(1'b1);
        chk({7'h0, n < 16}, 8'h01);
        $display("test fault shutdown done");
        close_out();
    end
endmodule // tb
